// ### hdl/dee_pkg.sv
// Constants and types shared by the data EEPROM access block
package dee_pkg;

  // ****************************************************************
  // Register map (word index; byte address is four times the index)
  // ****************************************************************
  localparam int unsigned ADR_W           = 12;
  localparam int unsigned IDX_W           = 10;
  localparam logic [9:0]  IDX_BYTE_BUFFER = 10'h09a;
  localparam logic [9:0]  IDX_CELL_INDEX  = 10'h09b;
  localparam logic [9:0]  IDX_NVM_CONTROL = 10'h09c;
  localparam logic [9:0]  IDX_UNLOCK_PORT = 10'h09d;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h0a0;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h0a1;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int unsigned CELLS      = 128;
  localparam int unsigned CELL_AW    = 7;
  localparam int unsigned CTL_FETCH  = 0;
  localparam int unsigned CTL_STORE  = 1;
  localparam int unsigned CTL_PERMIT = 2;
  localparam int unsigned IRQ_W      = 1;
  localparam int unsigned IRQ_DONE   = 0;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam logic [7:0]  UNLOCK_KEY_A = 8'h5a;
  localparam logic [7:0]  UNLOCK_KEY_B = 8'ha5;

  // ****************************************************************
  // Self-timed store cycle
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned US_NS           = 1000;
  localparam int unsigned ERASE_TIME_US   = 50;
  localparam int unsigned PROGRAM_TIME_US = 50;
  localparam int unsigned ERASE_CYC =
    (ERASE_TIME_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_CYC =
    (PROGRAM_TIME_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 12;
  localparam logic [TMR_W-1:0] ERASE_LOAD   = TMR_W'(ERASE_CYC - 1);
  localparam logic [TMR_W-1:0] PROGRAM_LOAD = TMR_W'(PROGRAM_CYC - 1);

  typedef enum logic [1:0] {TMR_IDLE, TMR_ERASE, TMR_PROGRAM} dee_tmr_t;
  typedef enum logic [1:0] {UNL_IDLE, UNL_HALF, UNL_OPEN} dee_unlock_t;

endpackage

// ### hdl/dee_mem_if.sv
// Port between the access logic and the cell array
`timescale 1ns/10ps
interface dee_mem_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       we;
  logic       re;
  modport ctrl  (output addr, output wdata, output we, output re,
                 input rdata);
  modport array (input addr, input wdata, input we, input re,
                 output rdata);
endinterface

// ### hdl/dee_cell_array.sv
// Byte-wide nonvolatile cell array with registered read data
`timescale 1ns/10ps
module dee_cell_array
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  dee_mem_if.array    mem
);

  typedef struct packed {
    logic [7:0] rdata;
  } dee_arr_st_t;

  dee_arr_st_t q;
  dee_arr_st_t d;
  logic [7:0]  cells_q [dee_pkg::CELLS];

  always_comb
  begin
    d = q;
    if (mem.re)
    begin
      d.rdata = cells_q[mem.addr];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
    // Array content survives reset
    if (mem.we)
    begin
      cells_q[mem.addr] <= mem.wdata;
    end
  end

  assign mem.rdata = q.rdata;

endmodule // dee_cell_array

// ### hdl/dee_store_timer.sv
// Self-timer for the erase-then-program store cycle
`timescale 1ns/10ps
module dee_store_timer
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      erase_o,
  output logic      done_o,
  output logic      busy_o
);

  typedef struct packed {
    dee_pkg::dee_tmr_t            state;
    logic [dee_pkg::TMR_W-1:0]    cnt;
  } dee_tmr_st_t;

  dee_tmr_st_t q;
  dee_tmr_st_t d;

  always_comb
  begin
    d       = q;
    erase_o = 1'b0;
    done_o  = 1'b0;
    case (q.state)
      dee_pkg::TMR_IDLE:
      begin
        if (start_i)
        begin
          d.state = dee_pkg::TMR_ERASE;
          d.cnt   = dee_pkg::ERASE_LOAD;
        end
      end
      dee_pkg::TMR_ERASE:
      begin
        if (q.cnt == '0)
        begin
          erase_o = 1'b1;
          d.state = dee_pkg::TMR_PROGRAM;
          d.cnt   = dee_pkg::PROGRAM_LOAD;
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      dee_pkg::TMR_PROGRAM:
      begin
        if (q.cnt == '0)
        begin
          done_o  = 1'b1;
          d.state = dee_pkg::TMR_IDLE;
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default:
      begin
        d.state = dee_pkg::TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign busy_o = (q.state != dee_pkg::TMR_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_erase_first;
    @(posedge clk_i) disable iff (rst_i)
    erase_o |-> !done_o ##1 (busy_o && !done_o && !erase_o);
  endproperty
  a_erase_first: assert property (p_erase_first)
    else $error("store program phase did not follow erase");

  property p_self_time;
    @(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o) |=> busy_o ##1 (busy_o && !done_o);
  endproperty
  a_self_time: assert property (p_self_time)
    else $error("store cycle did not run on its own timer");

endmodule // dee_store_timer

// ### hdl/dee_access_top.sv
// Wishbone access path to the 128-byte data EEPROM
// Notes on behaviour
// - A nonvolatile store of 128 bytes, cells 0 to 7Fh.
// - Software reads and writes the store one byte at a time.
// - Each store erases the cell first, then programs the new byte.
// - Store length comes from an internal timer; hardware signals end.
// - Store reached only through address, data and control registers; the programming port also reads and writes cells directly.
// - With protection on, the processor still reads and writes cells.
// - With protection on, the programming port is refused everything.
// - Eight-bit data register, read/write, resets to zero.
// - Address bits 6 to 0 select the cell; they reset to zero.
// - Unlock port has no storage; used only in the unlock sequence.
// - Fetch bit loads the addressed cell in one cycle, then self-clears.
// - Fetch and store bits are set-only; hardware clears on completion.
// - Stores need the permit bit, which is zero after reset.
// - Store completion sets a done flag that stays until cleared.
`timescale 1ns/10ps
module dee_access_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        protect_i,
  input  wire logic        prog_req_i,
  input  wire logic        prog_we_i,
  input  wire logic [6:0]  prog_addr_i,
  input  wire logic [7:0]  prog_wdata_i,
  output logic      [7:0]  prog_rdata_o,
  output logic             prog_ack_o,
  output logic             prog_refused_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                buffer;
    logic [dee_pkg::CELL_AW-1:0] index;
    logic                      fetch;
    logic                      store;
    logic                      permit;
    dee_pkg::dee_unlock_t      unlock;
    logic [dee_pkg::IRQ_W-1:0] status;
    logic [dee_pkg::IRQ_W-1:0] mask;
    logic                      ack;
    logic [31:0]               rdat;
    logic                      prog_pend;
    logic                      prog_ref;
    logic                      prog_ack;
    logic                      prog_refused;
    logic [7:0]                prog_rdata;
  } dee_top_st_t;

  dee_top_st_t q;
  dee_top_st_t d;

  dee_mem_if mem ();

  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic fetch_go;
  logic store_go;
  logic prog_free;
  logic prog_go;
  logic prog_ref_go;
  logic tmr_erase;
  logic tmr_done;
  logic tmr_busy;

  function automatic logic hit(input logic [11:0] adr,
                               input logic [9:0]  idx);
    hit = (adr[11:2] == idx);
  endfunction

  // ****************************************************************
  // Bus qualification and launches
  // ****************************************************************
  assign wb_req = cyc_i & stb_i;
  assign wb_wr  = wb_req & q.ack & we_i & sel_i[0];
  assign wb_rd  = wb_req & q.ack & ~we_i;

  assign fetch_go = wb_wr & hit(adr_i, dee_pkg::IDX_NVM_CONTROL) &
                    dat_i[dee_pkg::CTL_FETCH] & ~q.fetch & ~q.store;
  assign store_go = wb_wr & hit(adr_i, dee_pkg::IDX_NVM_CONTROL) &
                    dat_i[dee_pkg::CTL_STORE] & q.permit &
                    (q.unlock == dee_pkg::UNL_OPEN) &
                    ~q.store & ~q.fetch;

  assign prog_free   = prog_req_i & ~q.prog_pend & ~q.prog_ack &
                       ~wb_req & ~q.store & ~q.fetch;
  assign prog_go     = prog_free & ~protect_i;
  assign prog_ref_go = prog_req_i & ~q.prog_pend & ~q.prog_ack &
                       protect_i;

  // ****************************************************************
  // Cell array port
  // ****************************************************************
  assign mem.re    = fetch_go | (prog_go & ~prog_we_i);
  assign mem.we    = tmr_erase | tmr_done | (prog_go & prog_we_i);
  assign mem.addr  = prog_go ? prog_addr_i : q.index;
  assign mem.wdata = tmr_erase ? dee_pkg::ERASED :
                     (tmr_done ? q.buffer : prog_wdata_i);

  dee_cell_array u_array
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mem   (mem)
  );

  dee_store_timer u_timer
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (store_go),
    .erase_o (tmr_erase),
    .done_o  (tmr_done),
    .busy_o  (tmr_busy)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [31:0]               rd_val;
    logic [dee_pkg::IRQ_W-1:0] st_set;
    logic [dee_pkg::IRQ_W-1:0] st_clr;
    rd_val = '0;
    st_set = '0;
    st_clr = '0;
    d      = q;
    // Read data for the current request, taken one cycle before ack
    if (hit(adr_i, dee_pkg::IDX_BYTE_BUFFER))
    begin
      rd_val = 32'(q.buffer);
    end
    else if (hit(adr_i, dee_pkg::IDX_CELL_INDEX))
    begin
      rd_val = 32'(q.index);
    end
    else if (hit(adr_i, dee_pkg::IDX_NVM_CONTROL))
    begin
      rd_val = 32'({q.permit, q.store, q.fetch});
    end
    else if (hit(adr_i, dee_pkg::IDX_IRQ_STATUS))
    begin
      rd_val = 32'(q.status);
    end
    else if (hit(adr_i, dee_pkg::IDX_IRQ_MASK))
    begin
      rd_val = 32'(q.mask);
    end
    d.ack = wb_req & ~q.ack;
    if (wb_req & ~q.ack)
    begin
      d.rdat = rd_val;
    end
    // Register writes
    if (wb_wr)
    begin
      if (hit(adr_i, dee_pkg::IDX_BYTE_BUFFER))
      begin
        d.buffer = dat_i[7:0];
      end
      if (hit(adr_i, dee_pkg::IDX_CELL_INDEX))
      begin
        d.index = dat_i[dee_pkg::CELL_AW-1:0];
      end
      if (hit(adr_i, dee_pkg::IDX_NVM_CONTROL))
      begin
        d.permit = dat_i[dee_pkg::CTL_PERMIT];
        d.unlock = dee_pkg::UNL_IDLE;
      end
      if (hit(adr_i, dee_pkg::IDX_IRQ_MASK))
      begin
        d.mask = dat_i[dee_pkg::IRQ_W-1:0];
      end
      if (hit(adr_i, dee_pkg::IDX_UNLOCK_PORT))
      begin
        if (dat_i[7:0] == dee_pkg::UNLOCK_KEY_A)
        begin
          d.unlock = dee_pkg::UNL_HALF;
        end
        else if ((dat_i[7:0] == dee_pkg::UNLOCK_KEY_B) &&
                 (q.unlock == dee_pkg::UNL_HALF))
        begin
          d.unlock = dee_pkg::UNL_OPEN;
        end
        else
        begin
          d.unlock = dee_pkg::UNL_IDLE;
        end
      end
    end
    // Launch bits are set-only from the bus
    if (fetch_go)
    begin
      d.fetch = 1'b1;
    end
    if (store_go)
    begin
      d.store = 1'b1;
    end
    if (q.fetch)
    begin
      d.buffer = mem.rdata;
      d.fetch  = 1'b0;
    end
    if (tmr_done)
    begin
      d.store = 1'b0;
      st_set[dee_pkg::IRQ_DONE] = 1'b1;
    end
    // Read of status clears it; a new event wins
    if (wb_rd && hit(adr_i, dee_pkg::IDX_IRQ_STATUS))
    begin
      st_clr = '1;
    end
    d.status = (q.status & ~st_clr) | st_set;
    // Programming port
    d.prog_ack = q.prog_pend;
    d.prog_pend = prog_go | prog_ref_go;
    if (prog_go | prog_ref_go)
    begin
      d.prog_ref = prog_ref_go;
    end
    if (q.prog_pend)
    begin
      d.prog_refused = q.prog_ref;
      d.prog_rdata   = q.prog_ref ? '0 : mem.rdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dat_o          = q.rdat;
  assign ack_o          = q.ack;
  assign irq_o          = |(q.status & q.mask);
  assign prog_ack_o     = q.prog_ack;
  assign prog_refused_o = q.prog_refused;
  assign prog_rdata_o   = q.prog_rdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_fetch_one;
    q.fetch |=> !q.fetch && (q.buffer == $past(mem.rdata));
  endproperty
  a_fetch_one: assert property (p_fetch_one)
    else $error("fetch did not load and clear in one cycle");

  property p_fetch_protected;
    (fetch_go && protect_i) |=> q.fetch ##1
      (!q.fetch && (q.buffer == $past(mem.rdata)));
  endproperty
  a_fetch_protected: assert property (p_fetch_protected)
    else $error("processor fetch was not launched");

  property p_store_permit;
    $rose(q.store) |-> $past(q.permit) &&
                       ($past(q.unlock) == dee_pkg::UNL_OPEN);
  endproperty
  a_store_permit: assert property (p_store_permit)
    else $error("store started without permit and unlock");

  property p_store_hold;
    (q.store && !tmr_done) |=> q.store && tmr_busy;
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("store bit cleared before completion");

  property p_done_flag;
    tmr_done |=> q.status[dee_pkg::IRQ_DONE] && !q.store;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("store completion did not set the done flag");

  property p_index_top;
    (ack_o && !we_i && hit(adr_i, dee_pkg::IDX_CELL_INDEX))
      |-> (dat_o[7] == 1'b0);
  endproperty
  a_index_top: assert property (p_index_top)
    else $error("address bit 7 read back as one");

  property p_unlock_zero;
    (ack_o && !we_i && hit(adr_i, dee_pkg::IDX_UNLOCK_PORT))
      |-> (dat_o == 32'h0000_0000);
  endproperty
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("unlock port read nonzero");

  property p_prog_refuse;
    q.prog_ack |-> (q.prog_refused == $past(protect_i, 2));
  endproperty
  a_prog_refuse: assert property (p_prog_refuse)
    else $error("programming access not refused under protection");

endmodule // dee_access_top

// ### testbench/dee_prog_model.sv
// External programmer model driving the programming port
`timescale 1ns/10ps
module dee_prog_model
(
  input  wire logic       clk_i,
  input  wire logic       prog_ack_i,
  input  wire logic [7:0] prog_rdata_i,
  input  wire logic       prog_refused_i,
  output logic            prog_req_o,
  output logic            prog_we_o,
  output logic      [6:0] prog_addr_o,
  output logic      [7:0] prog_wdata_o
);
  initial
  begin
    prog_req_o   = 1'b0;
    prog_we_o    = 1'b0;
    prog_addr_o  = 7'h2a;
    prog_wdata_o = 8'h55;
  end

  // ****************************************************************
  // One byte transfer, held until acknowledged
  // ****************************************************************
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] r,
                      output logic rf);
    int n;
    n = 0;
    prog_req_o   <= 1'b1;
    prog_we_o    <= w;
    prog_addr_o  <= a;
    prog_wdata_o <= d;
    @(posedge clk_i);
    while (prog_ack_i !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    r  = prog_rdata_i;
    rf = prog_refused_i;
    // No answer: leave the results unknown so the checks fail
    if (n == 20)
    begin
      r  = 8'hxx;
      rf = 1'bx;
    end
    // Released lines stop showing the old value
    prog_req_o   <= 1'b0;
    prog_we_o    <= ~w;
    prog_addr_o  <= ~a;
    prog_wdata_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // dee_prog_model

// ### testbench/data_eeprom_access_bench.sv
// Self-checking bench for the data EEPROM access path
`timescale 1ns/10ps
module data_eeprom_access_bench;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_o;
  logic        protect_i;
  logic        p_req;
  logic        p_we;
  logic [6:0]  p_addr;
  logic [7:0]  p_wdata;
  logic [7:0]  p_rdata;
  logic        p_ack;
  logic        p_ref;
  int          n_fail;
  int          check_count;
  int          cycles = 0;
  logic [7:0]  r;
  logic        rf;

  dee_access_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .protect_i(protect_i), .prog_req_i(p_req), .prog_we_i(p_we),
    .prog_addr_i(p_addr), .prog_wdata_i(p_wdata),
    .prog_rdata_o(p_rdata), .prog_ack_o(p_ack), .prog_refused_o(p_ref));

  dee_prog_model u_prog (.clk_i(clk_i), .prog_ack_i(p_ack),
    .prog_rdata_i(p_rdata), .prog_refused_i(p_ref), .prog_req_o(p_req),
    .prog_we_o(p_we), .prog_addr_o(p_addr), .prog_wdata_o(p_wdata));

  initial
  begin
    clk_i = 1'b0;
  end
  always #20 clk_i = ~clk_i;

  // ****************************************************************
  // Reporting and bus tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [9:0] idx,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      chk(8'h00, 8'h01, "no bus ack");
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic unlock();
    wb(1'b1, dee_pkg::IDX_UNLOCK_PORT, dee_pkg::UNLOCK_KEY_A, r);
    wb(1'b1, dee_pkg::IDX_UNLOCK_PORT, dee_pkg::UNLOCK_KEY_B, r);
  endtask

  task automatic store(input logic [6:0] a, input logic [7:0] d);
    int n;
    logic [7:0] q;
    n = 0;
    wb(1'b1, dee_pkg::IDX_CELL_INDEX, {1'b0, a}, q);
    wb(1'b1, dee_pkg::IDX_BYTE_BUFFER, d, q);
    wb(1'b1, dee_pkg::IDX_NVM_CONTROL, 8'h04, q);
    unlock();
    wb(1'b1, dee_pkg::IDX_NVM_CONTROL, 8'h06, q);
    wb(1'b0, dee_pkg::IDX_NVM_CONTROL, 8'h00, q);
    chk(q & 8'h02, 8'h02, "store not running");
    wb(1'b1, dee_pkg::IDX_NVM_CONTROL, 8'h04, q);
    wb(1'b0, dee_pkg::IDX_NVM_CONTROL, 8'h00, q);
    chk(q & 8'h02, 8'h02, "store cleared by write");
    do
    begin
      wb(1'b0, dee_pkg::IDX_NVM_CONTROL, 8'h00, q);
      n++;
    end
    while (q[1] === 1'b1 && n < 1500);
    chk(q, 8'h04, "store did not end");
    chk({7'h00, irq_o}, 8'h01, "no irq after store");
    wb(1'b1, dee_pkg::IDX_IRQ_MASK, 8'h00, q);
    chk({7'h00, irq_o}, 8'h00, "irq not masked");
    wb(1'b1, dee_pkg::IDX_IRQ_MASK, 8'h01, q);
    chk({7'h00, irq_o}, 8'h01, "irq lost under mask");
    wb(1'b0, dee_pkg::IDX_IRQ_STATUS, 8'h00, q);
    chk(q, 8'h01, "done flag missing");
    wb(1'b0, dee_pkg::IDX_IRQ_STATUS, 8'h00, q);
    chk(q, 8'h00, "done flag not cleared");
    chk({7'h00, irq_o}, 8'h00, "irq stuck");
  endtask

  task automatic fetch(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, dee_pkg::IDX_CELL_INDEX, {1'b0, a}, q);
    wb(1'b1, dee_pkg::IDX_NVM_CONTROL, 8'h05, q);
    wb(1'b0, dee_pkg::IDX_BYTE_BUFFER, 8'h00, d);
    wb(1'b0, dee_pkg::IDX_NVM_CONTROL, 8'h00, q);
    chk(q, 8'h04, "fetch bit stuck");
  endtask

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    n_fail = 0;
    check_count = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 12'h000;
    sel_i = 4'h0;
    dat_i = 32'h00000000;
    protect_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, dee_pkg::IDX_BYTE_BUFFER, 8'h00, r);
    chk(r, dee_pkg::BYTE_RST, "data reset");
    wb(1'b0, dee_pkg::IDX_CELL_INDEX, 8'h00, r);
    chk(r, 8'h00, "index reset");
    wb(1'b0, dee_pkg::IDX_NVM_CONTROL, 8'h00, r);
    chk(r, 8'h00, "control reset");
    wb(1'b1, dee_pkg::IDX_BYTE_BUFFER, 8'h3c, r);
    wb(1'b0, dee_pkg::IDX_BYTE_BUFFER, 8'h00, r);
    chk(r, 8'h3c, "data readback");
    wb(1'b1, dee_pkg::IDX_CELL_INDEX, 8'hff, r);
    wb(1'b0, dee_pkg::IDX_CELL_INDEX, 8'h00, r);
    chk(r, 8'h7f, "index top bit");
    wb(1'b0, 10'h3ff, 8'h00, r);
    chk(r, 8'h00, "unmapped read");
    wb(1'b1, dee_pkg::IDX_UNLOCK_PORT, dee_pkg::UNLOCK_KEY_A, r);
    wb(1'b0, dee_pkg::IDX_UNLOCK_PORT, 8'h00, r);
    chk(r, 8'h00, "unlock port storage");
    unlock();
    wb(1'b1, dee_pkg::IDX_NVM_CONTROL, 8'h02, r);
    wb(1'b0, dee_pkg::IDX_NVM_CONTROL, 8'h00, r);
    chk(r, 8'h00, "store without permit");
    wb(1'b1, dee_pkg::IDX_IRQ_MASK, 8'h01, r);
    store(7'h7f, 8'h96);
    store(7'h00, 8'h5c);
    fetch(7'h7f, r);
    chk(r, 8'h96, "fetch top cell");
    fetch(7'h00, r);
    chk(r, 8'h5c, "fetch cell zero");
    u_prog.xfer(1'b0, 7'h7f, 8'h00, r, rf);
    chk(r, 8'h96, "prog read");
    chk({7'h00, rf}, 8'h00, "prog refused open");
    u_prog.xfer(1'b1, 7'h00, 8'h77, r, rf);
    fetch(7'h00, r);
    chk(r, 8'h77, "prog write");
    protect_i <= 1'b1;
    u_prog.xfer(1'b1, 7'h7f, 8'h11, r, rf);
    chk({7'h00, rf}, 8'h01, "prog write accepted");
    u_prog.xfer(1'b0, 7'h7f, 8'h00, r, rf);
    chk(r, 8'h00, "prog read leaked");
    fetch(7'h7f, r);
    chk(r, 8'h96, "protected fetch");
    store(7'h7f, 8'h22);
    fetch(7'h7f, r);
    chk(r, 8'h22, "protected store");
    protect_i <= 1'b0;
    u_prog.xfer(1'b0, 7'h7f, 8'h00, r, rf);
    chk(r, 8'h22, "prog after protect");
    report_and_stop();
  end
endmodule // data_eeprom_access_bench
